// [shared/etm_pkg.sv]
// Constants shared by the external trigger measurement handshake block.
package etm_pkg;
    // Clock and time base: one enable tick every 100 us.
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_US        = 100;
    localparam int TICK_CYCLES_DF = TICK_US * 1000 / CLK_PERIOD_NS;
    // Handshake times in microseconds, and derived tick counts.
    localparam int MEASURE_TRIGGER_N_LOW_WIDTH_US  = 100;
    localparam int MEASURE_TRIGGER_N_TO_STROBE_US  = 500;
    localparam int PANEL_LOAD_US      = 1000000;
    localparam int DELAY_TICKS        = (MEASURE_TRIGGER_N_TO_STROBE_US + TICK_US - 1) / TICK_US;
    localparam int PANEL_LOAD_TICKS_DF = (PANEL_LOAD_US + TICK_US - 1) / TICK_US;
    // Analog phase pulse widths in microseconds, by frequency and speed.
    localparam int AP_120_FAST_US = 8300;
    localparam int AP_120_NORM_US = 17000;
    localparam int AP_120_SLOW_US = 67000;
    localparam int AP_1K_FAST_US  = 1000;
    localparam int AP_1K_NORM_US  = 4000;
    localparam int AP_1K_SLOW_US  = 8000;
    // Analog phase pulse counts per test.
    localparam int AP_CNT_FAST    = 1;
    localparam int AP_CNT_120_NORM = 4;
    localparam int AP_CNT_120_SLOW = 5;
    localparam int AP_CNT_1K_NORM = 7;
    localparam int AP_CNT_1K_SLOW = 24;
    // Base conversion times in microseconds.
    localparam int BASE_120_FAST_US = 13000;
    localparam int BASE_120_NORM_US = 90000;
    localparam int BASE_120_SLOW_US = 400000;
    localparam int BASE_1K_FAST_US  = 5000;
    localparam int BASE_1K_NORM_US  = 60000;
    localparam int BASE_1K_SLOW_US  = 300000;
    // Added calculation times in microseconds.
    localparam int CALC_LOSS_US = 1500;
    localparam int CALC_RES_US  = 1000;
    localparam int COMP_US      = 1000;
    localparam int CMP_US       = 100;
    // Register offsets.
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] COUNT_OFS  = 8'h08;
    // Control field positions and reset value.
    localparam int CTRL_EXT_BIT  = 0;
    localparam int CTRL_CMP_BIT  = 1;
    localparam int CTRL_FREQ_BIT = 2;
    localparam int CTRL_SPD_LSB  = 3;
    localparam int CTRL_DSP_LSB  = 5;
    localparam int CTRL_COMP_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Speed and display codes.
    localparam logic [1:0] SPD_FAST = 2'h0;
    localparam logic [1:0] SPD_NORM = 2'h1;
    localparam logic [1:0] SPD_SLOW = 2'h2;
    localparam logic [1:0] DSP_ZTH  = 2'h0;
    localparam logic [1:0] DSP_CD   = 2'h1;
    localparam logic [1:0] DSP_LD   = 2'h2;
    localparam logic [1:0] DSP_R    = 2'h3;
    // Comparator result codes from the measuring core.
    localparam logic [1:0] CMP_IN    = 2'h0;
    localparam logic [1:0] CMP_ABOVE = 2'h1;
    localparam logic [1:0] CMP_BELOW = 2'h2;
    // Sequencer states, one-hot.
    typedef enum logic [4:0] {
        S_IDLE    = 5'h01,
        S_LOAD    = 5'h02,
        S_DELAY   = 5'h04,
        S_CONVERT = 5'h08,
        S_FINISH  = 5'h10
    } etm_state_e;
endpackage : etm_pkg

// [logic/etm_handshake.sv]
// Measurement handshake sequencer for the external control connector.
`timescale 1ns/10ps
`default_nettype none
module etm_handshake #(
    parameter int TICK_CYCLES      = etm_pkg::TICK_CYCLES_DF,
    parameter int PANEL_LOAD_TICKS = etm_pkg::PANEL_LOAD_TICKS_DF
) (
    // Clock and reset.
    input  wire logic        SYS_CLK,
    input  wire logic        RESET,
    // Register port.
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    // Connector inputs and front panel key.
    input  wire logic        MEASURE_TRIGGER_N,
    input  wire logic [3:0]  PANEL_SEL_ONES,
    input  wire logic [3:0]  PANEL_SEL_TENS,
    input  wire logic        START_KEY,
    // Comparator codes from the measuring core.
    input  wire logic [1:0]  FIRST_CMP_CODE,
    input  wire logic [1:0]  SECOND_CMP_CODE,
    // Connector outputs, all active low.
    output logic             ANALOG_PHASE_N,
    output logic             MEASURE_BUSY_N,
    output logic             FIRST_PARAM_ABOVE_N,
    output logic             FIRST_PARAM_IN_N,
    output logic             FIRST_PARAM_BELOW_N,
    output logic             SECOND_PARAM_ABOVE_N,
    output logic             SECOND_PARAM_IN_N,
    output logic             SECOND_PARAM_BELOW_N,
    output logic             BOTH_IN_N
);
    localparam int TW = $clog2(TICK_CYCLES + 1);

    // Parameter values the counters cannot serve are refused.
    if (TICK_CYCLES < 2 || PANEL_LOAD_TICKS < 1 || PANEL_LOAD_TICKS > 65535) begin : g_bad_param
        $error("etm_handshake: tick or panel load count out of range");
    end

    // Converts a time in microseconds to whole ticks, rounded up.
    function automatic logic [11:0] to_ticks(input int us);
        to_ticks = 12'((us + etm_pkg::TICK_US - 1) / etm_pkg::TICK_US);
    endfunction : to_ticks

    // Analog pulse width for a speed and frequency.
    function automatic logic [11:0] ap_width(input logic [1:0] spd, input logic f1k);
        if (spd == etm_pkg::SPD_NORM) begin
            ap_width = f1k ? to_ticks(etm_pkg::AP_1K_NORM_US) : to_ticks(etm_pkg::AP_120_NORM_US);
        end else if (spd == etm_pkg::SPD_SLOW) begin
            ap_width = f1k ? to_ticks(etm_pkg::AP_1K_SLOW_US) : to_ticks(etm_pkg::AP_120_SLOW_US);
        end else begin
            ap_width = f1k ? to_ticks(etm_pkg::AP_1K_FAST_US) : to_ticks(etm_pkg::AP_120_FAST_US);
        end
    endfunction : ap_width

    // Number of analog pulses for a speed and frequency.
    function automatic logic [4:0] ap_count(input logic [1:0] spd, input logic f1k);
        if (spd == etm_pkg::SPD_NORM) begin
            ap_count = f1k ? 5'(etm_pkg::AP_CNT_1K_NORM) : 5'(etm_pkg::AP_CNT_120_NORM);
        end else if (spd == etm_pkg::SPD_SLOW) begin
            ap_count = f1k ? 5'(etm_pkg::AP_CNT_1K_SLOW) : 5'(etm_pkg::AP_CNT_120_SLOW);
        end else begin
            ap_count = 5'(etm_pkg::AP_CNT_FAST);
        end
    endfunction : ap_count

    // Busy duration: base plus display, compensation and comparator parts.
    function automatic logic [11:0] busy_ticks(input logic [7:0] c);
        logic [1:0]  spd;
        logic        f1k;
        logic [11:0] sum;
        spd = c[etm_pkg::CTRL_SPD_LSB +: 2];
        f1k = c[etm_pkg::CTRL_FREQ_BIT];
        if (spd == etm_pkg::SPD_NORM) begin
            sum = f1k ? to_ticks(etm_pkg::BASE_1K_NORM_US) : to_ticks(etm_pkg::BASE_120_NORM_US);
        end else if (spd == etm_pkg::SPD_SLOW) begin
            sum = f1k ? to_ticks(etm_pkg::BASE_1K_SLOW_US) : to_ticks(etm_pkg::BASE_120_SLOW_US);
        end else begin
            sum = f1k ? to_ticks(etm_pkg::BASE_1K_FAST_US) : to_ticks(etm_pkg::BASE_120_FAST_US);
        end
        if (c[etm_pkg::CTRL_DSP_LSB +: 2] == etm_pkg::DSP_CD || c[etm_pkg::CTRL_DSP_LSB +: 2] == etm_pkg::DSP_LD) begin
            sum = sum + to_ticks(etm_pkg::CALC_LOSS_US);
        end else if (c[etm_pkg::CTRL_DSP_LSB +: 2] == etm_pkg::DSP_R) begin
            sum = sum + to_ticks(etm_pkg::CALC_RES_US);
        end
        if (c[etm_pkg::CTRL_COMP_BIT]) begin
            sum = sum + to_ticks(etm_pkg::COMP_US);
        end
        if (c[etm_pkg::CTRL_CMP_BIT]) begin
            sum = sum + to_ticks(etm_pkg::CMP_US);
        end
        busy_ticks = sum;
    endfunction : busy_ticks

    logic [7:0]          ctrl;
    logic [7:0]          cfg;
    logic [15:0]         test_count;
    logic [TW-1:0]       div_cnt;
    logic                tick;
    logic                measure_trigger_n_prev;
    logic                start;
    logic                sel_valid;
    logic [6:0]          sel_panel;
    logic [6:0]          loaded_panel;
    etm_pkg::etm_state_e state;
    logic [15:0]         wait_cnt;
    logic [11:0]         busy_rem;
    logic [11:0]         ap_cnt;
    logic [4:0]          ap_left;
    logic                enter_convert;

    // Time base divider producing a one-cycle tick every 100 us.
    always_ff @(posedge SYS_CLK) begin
        if (RESET || div_cnt == TW'(TICK_CYCLES - 1)) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end
    always_ff @(posedge SYS_CLK) begin
        tick <= !RESET && div_cnt == TW'(TICK_CYCLES - 1);
    end

    // Start on a trigger falling edge or a key press in external mode.
    always_ff @(posedge SYS_CLK) begin
        measure_trigger_n_prev <= RESET ? 1'b1 : MEASURE_TRIGGER_N;
    end
    assign start = ctrl[etm_pkg::CTRL_EXT_BIT] && ((measure_trigger_n_prev && !MEASURE_TRIGGER_N) || START_KEY);

    // Panel digits decode; codes above nine are not loaded.
    assign sel_valid = PANEL_SEL_ONES <= 4'h9 && PANEL_SEL_TENS <= 4'h9;
    // Both digits are widened first so that tens times ten cannot wrap in four bits.
    assign sel_panel = 7'(PANEL_SEL_TENS) * 7'h0a + 7'(PANEL_SEL_ONES);
    assign enter_convert = state == etm_pkg::S_DELAY && tick && wait_cnt == 16'h0001;

    // Sequencer; any start outside idle is ignored.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state <= etm_pkg::S_IDLE;
            wait_cnt <= '0;
        end else begin
            case (state)
                etm_pkg::S_IDLE: begin
                    if (start) begin
                        if (sel_valid && sel_panel != loaded_panel) begin
                            state <= etm_pkg::S_LOAD;
                            wait_cnt <= 16'(PANEL_LOAD_TICKS);
                        end else begin
                            state <= etm_pkg::S_DELAY;
                            wait_cnt <= 16'(etm_pkg::DELAY_TICKS);
                        end
                    end
                end
                etm_pkg::S_LOAD: begin
                    if (tick && wait_cnt == 16'h0001) begin
                        state <= etm_pkg::S_DELAY;
                        wait_cnt <= 16'(etm_pkg::DELAY_TICKS);
                    end else if (tick) begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end
                end
                etm_pkg::S_DELAY: begin
                    if (enter_convert) begin
                        state <= etm_pkg::S_CONVERT;
                    end else if (tick) begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end
                end
                etm_pkg::S_CONVERT: begin
                    if (tick && busy_rem == 12'h001) begin
                        state <= etm_pkg::S_FINISH;
                    end
                end
                etm_pkg::S_FINISH: begin
                    state <= etm_pkg::S_IDLE;
                end
                default: begin
                    state <= etm_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Loaded panel and configuration snapshot taken when a test is accepted.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            loaded_panel <= '0;
            cfg <= etm_pkg::CTRL_RESET;
        end else if (state == etm_pkg::S_IDLE && start) begin
            cfg <= ctrl;
            if (sel_valid) begin
                loaded_panel <= sel_panel;
            end
        end
    end

    // Busy strobe and remaining test time.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            MEASURE_BUSY_N <= 1'b1;
            busy_rem <= '0;
        end else if (enter_convert) begin
            MEASURE_BUSY_N <= 1'b0;
            busy_rem <= busy_ticks(cfg);
        end else if (state == etm_pkg::S_FINISH) begin
            MEASURE_BUSY_N <= 1'b1;
        end else if (state == etm_pkg::S_CONVERT && tick) begin
            busy_rem <= busy_rem - 1'b1;
        end
    end

    // Analog phase pulses with a one tick gap between them.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ANALOG_PHASE_N <= 1'b1;
            ap_cnt <= '0;
            ap_left <= '0;
        end else if (enter_convert) begin
            ANALOG_PHASE_N <= 1'b0;
            ap_cnt <= ap_width(cfg[etm_pkg::CTRL_SPD_LSB +: 2], cfg[etm_pkg::CTRL_FREQ_BIT]);
            ap_left <= ap_count(cfg[etm_pkg::CTRL_SPD_LSB +: 2], cfg[etm_pkg::CTRL_FREQ_BIT]) - 1'b1;
        end else if (state == etm_pkg::S_CONVERT && tick) begin
            if (!ANALOG_PHASE_N) begin
                if (ap_cnt == 12'h001) begin
                    ANALOG_PHASE_N <= 1'b1;
                end
                ap_cnt <= ap_cnt - 1'b1;
            end else if (ap_left != 5'h00) begin
                ANALOG_PHASE_N <= 1'b0;
                ap_cnt <= ap_width(cfg[etm_pkg::CTRL_SPD_LSB +: 2], cfg[etm_pkg::CTRL_FREQ_BIT]);
                ap_left <= ap_left - 1'b1;
            end
        end
    end

    // Result lines: cleared at test start, set one cycle before busy ends.
    always_ff @(posedge SYS_CLK) begin
        if (RESET || (state == etm_pkg::S_IDLE && start)) begin
            {FIRST_PARAM_ABOVE_N, FIRST_PARAM_IN_N, FIRST_PARAM_BELOW_N} <= 3'h7;
            {SECOND_PARAM_ABOVE_N, SECOND_PARAM_IN_N, SECOND_PARAM_BELOW_N} <= 3'h7;
            BOTH_IN_N <= 1'b1;
        end else if (state == etm_pkg::S_CONVERT && tick && busy_rem == 12'h001 && cfg[etm_pkg::CTRL_CMP_BIT]) begin
            FIRST_PARAM_ABOVE_N <= FIRST_CMP_CODE != etm_pkg::CMP_ABOVE;
            FIRST_PARAM_IN_N <= FIRST_CMP_CODE != etm_pkg::CMP_IN;
            FIRST_PARAM_BELOW_N <= FIRST_CMP_CODE != etm_pkg::CMP_BELOW;
            SECOND_PARAM_ABOVE_N <= SECOND_CMP_CODE != etm_pkg::CMP_ABOVE;
            SECOND_PARAM_IN_N <= SECOND_CMP_CODE != etm_pkg::CMP_IN;
            SECOND_PARAM_BELOW_N <= SECOND_CMP_CODE != etm_pkg::CMP_BELOW;
            BOTH_IN_N <= !(FIRST_CMP_CODE == etm_pkg::CMP_IN && SECOND_CMP_CODE == etm_pkg::CMP_IN);
        end
    end

    // Control register write and completed test counter.
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ctrl <= etm_pkg::CTRL_RESET;
        end else if (REG_WR && REG_ADDR == etm_pkg::CTRL_OFS) begin
            ctrl <= REG_WDATA[7:0];
        end
    end
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            test_count <= '0;
        end else if (state == etm_pkg::S_FINISH) begin
            test_count <= test_count + 1'b1;
        end
    end

    // Read data one cycle after the read strobe; unmapped reads zero.
    always_ff @(posedge SYS_CLK) begin
        if (RESET || !REG_RD) begin
            REG_RDATA <= '0;
        end else if (REG_ADDR == etm_pkg::CTRL_OFS) begin
            REG_RDATA <= {24'h000000, ctrl};
        end else if (REG_ADDR == etm_pkg::STATUS_OFS) begin
            REG_RDATA <= {17'h00000, loaded_panel, 2'h0, state, !MEASURE_BUSY_N};
        end else if (REG_ADDR == etm_pkg::COUNT_OFS) begin
            REG_RDATA <= {16'h0000, test_count};
        end else begin
            REG_RDATA <= '0;
        end
    end

    // Helper counters read only by the checks below.
    logic [11:0] chk_ap_len;
    logic [11:0] chk_busy_len;
    logic [4:0]  chk_pulses;
    always_ff @(posedge SYS_CLK) begin
        if (RESET || enter_convert) begin
            chk_busy_len <= '0;
            chk_pulses <= '0;
        end else begin
            if (tick && state == etm_pkg::S_CONVERT) begin
                chk_busy_len <= chk_busy_len + 1'b1;
            end
            if ($fell(ANALOG_PHASE_N)) begin
                chk_pulses <= chk_pulses + 1'b1;
            end
        end
        if (RESET || ANALOG_PHASE_N) begin
            chk_ap_len <= '0;
        end else if (tick) begin
            chk_ap_len <= chk_ap_len + 1'b1;
        end
    end

    a_strobe_after_delay: assert property (@(posedge SYS_CLK) disable iff (RESET)
        enter_convert |=> !ANALOG_PHASE_N && !MEASURE_BUSY_N) else $error("strobes did not start after delay");
    a_load_new_panel: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (state == etm_pkg::S_IDLE && start && sel_valid && sel_panel != loaded_panel) |=> state == etm_pkg::S_LOAD)
        else $error("new panel was not loaded");
    a_strobe_inside_busy: assert property (@(posedge SYS_CLK) disable iff (RESET)
        !ANALOG_PHASE_N |-> !MEASURE_BUSY_N) else $error("analog strobe outside busy");
    a_pulse_count: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $rose(MEASURE_BUSY_N) |-> chk_pulses == ap_count(cfg[etm_pkg::CTRL_SPD_LSB +: 2], cfg[etm_pkg::CTRL_FREQ_BIT]))
        else $error("wrong analog pulse count");
    a_pulse_width: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $rose(ANALOG_PHASE_N) |-> chk_ap_len == ap_width(cfg[etm_pkg::CTRL_SPD_LSB +: 2], cfg[etm_pkg::CTRL_FREQ_BIT]))
        else $error("wrong analog pulse width");
    a_busy_length: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $rose(MEASURE_BUSY_N) |-> chk_busy_len == busy_ticks(cfg)) else $error("wrong busy length");
    a_pass_both_in: assert property (@(posedge SYS_CLK) disable iff (RESET)
        !BOTH_IN_N |-> !FIRST_PARAM_IN_N && !SECOND_PARAM_IN_N) else $error("pass without both in");
    a_results_stable: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $rose(MEASURE_BUSY_N) |-> $stable({FIRST_PARAM_IN_N, SECOND_PARAM_IN_N, BOTH_IN_N}))
        else $error("results changed with busy end");
    a_retrigger_ignored: assert property (@(posedge SYS_CLK) disable iff (RESET)
        (state == etm_pkg::S_CONVERT && start && !(tick && busy_rem == 12'h001)) |=> state == etm_pkg::S_CONVERT)
        else $error("trigger disturbed a running test");
    a_one_test_edge: assert property (@(posedge SYS_CLK) disable iff (RESET)
        $rose(state != etm_pkg::S_IDLE) |-> $past(start)) else $error("test began without trigger");
endmodule : etm_handshake
`default_nettype wire

// [dv/etm_handler_model.sv]
// Handler model: drives the trigger and panel lines and times the meter strobes.
`timescale 1ns/10ps
`default_nettype none
module etm_handler_model #(
    parameter int LOW_CYCLES = 4
) (
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       reset,
    // Requests from the bench.
    input  wire logic       fire,
    input  wire logic       retrig,
    input  wire logic [7:0] panel,
    // Strobes from the meter.
    input  wire logic       analog_phase_n,
    input  wire logic       measure_busy_n,
    // Connector lines driven by the handler.
    output logic            measure_trigger_n,
    output logic      [7:0] panel_sel,
    // Measured times in clock cycles and the analog pulse count.
    output int              delay_cyc,
    output int              busy_cyc,
    output int              pulse_cnt,
    output int              pulse_cyc
);
    logic busy_q = 1'b1;
    logic ap_q   = 1'b1;
    int   low_left;
    int   since;
    int   blen;
    int   alen;
    // Lines idle high; the panel digits start at 00.
    initial begin
        measure_trigger_n = 1'b1;
        panel_sel = 8'h00;
    end
    // Trigger is a low pulse of LOW_CYCLES, refired at once when busy ends if asked.
    always @(posedge clk) begin
        since <= since + 1;
        if (reset) begin
            measure_trigger_n <= 1'b1;
            low_left <= 0;
        end else if (low_left == 0 && (fire || (retrig && measure_busy_n && !busy_q))) begin
            measure_trigger_n <= 1'b0;
            low_left <= LOW_CYCLES;
            panel_sel <= panel;
            since <= 0;
        end else if (low_left == 1) begin
            measure_trigger_n <= 1'b1;
            low_left <= 0;
        end else if (low_left > 1) begin
            low_left <= low_left - 1;
        end
    end
    // Strobe timing; the sample is only swapped once the analog strobe is high again.
    always @(posedge clk) begin
        busy_q <= measure_busy_n;
        ap_q <= analog_phase_n;
        blen <= measure_busy_n ? 0 : blen + 1;
        alen <= analog_phase_n ? 0 : alen + 1;
        if (!measure_busy_n && busy_q) begin
            delay_cyc <= since;
            pulse_cnt <= int'(!analog_phase_n);
        end else if (!analog_phase_n && ap_q) begin
            pulse_cnt <= pulse_cnt + 1;
        end
        if (analog_phase_n && !ap_q && pulse_cnt == 1) pulse_cyc <= alen;
        if (measure_busy_n && !busy_q) busy_cyc <= blen;
    end
endmodule : etm_handler_model
`default_nettype wire

// [dv/etm_handshake_tb_top.sv]
// Self-checking bench for the measurement handshake sequencer.
`timescale 1ns/10ps
`default_nettype none
module etm_handshake_tb_top;
    logic        SYS_CLK = 1'b0;
    logic        RESET = 1'b1;
    logic [7:0]  REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0;
    logic        REG_WR = 1'b0;
    logic        REG_RD = 1'b0;
    logic [31:0] REG_RDATA;
    logic        MEASURE_TRIGGER_N;
    wire logic [7:0] panel_sel;
    logic        START_KEY = 1'b0;
    logic [1:0]  FIRST_CMP_CODE = 2'h0;
    logic [1:0]  SECOND_CMP_CODE = 2'h0;
    logic        ANALOG_PHASE_N;
    logic        MEASURE_BUSY_N;
    logic [6:0]  results;
    logic        fire = 1'b0;
    logic        retrig = 1'b0;
    logic [7:0]  panel = 8'h00;
    int          delay_cyc, busy_cyc, pulse_cnt, pulse_cyc;
    int          fails = 0, comparisons = 0, cycles = 0, tests = 0;
    // Times in 100 us ticks and pulse counts by frequency (120 Hz, 1 kHz) and speed (FAST, NORM, SLOW).
    int base_t [2][3] = '{'{130, 900, 4000}, '{50, 600, 3000}};
    int ap_t   [2][3] = '{'{83, 170, 670}, '{10, 40, 80}};
    int ap_n   [2][3] = '{'{1, 4, 5}, '{1, 7, 24}};
    etm_handshake #(.TICK_CYCLES(4), .PANEL_LOAD_TICKS(3)) etm_handshake_inst (
        .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .MEASURE_TRIGGER_N(MEASURE_TRIGGER_N),
        .PANEL_SEL_ONES(panel_sel[3:0]), .PANEL_SEL_TENS(panel_sel[7:4]), .START_KEY(START_KEY),
        .FIRST_CMP_CODE(FIRST_CMP_CODE), .SECOND_CMP_CODE(SECOND_CMP_CODE), .ANALOG_PHASE_N(ANALOG_PHASE_N),
        .MEASURE_BUSY_N(MEASURE_BUSY_N), .FIRST_PARAM_ABOVE_N(results[6]), .FIRST_PARAM_IN_N(results[5]),
        .FIRST_PARAM_BELOW_N(results[4]), .SECOND_PARAM_ABOVE_N(results[3]), .SECOND_PARAM_IN_N(results[2]),
        .SECOND_PARAM_BELOW_N(results[1]), .BOTH_IN_N(results[0]));
    etm_handler_model #(.LOW_CYCLES(4)) etm_handler_model_inst (
        .clk(SYS_CLK), .reset(RESET), .fire(fire), .retrig(retrig), .panel(panel),
        .analog_phase_n(ANALOG_PHASE_N), .measure_busy_n(MEASURE_BUSY_N), .measure_trigger_n(MEASURE_TRIGGER_N),
        .panel_sel(panel_sel), .delay_cyc(delay_cyc), .busy_cyc(busy_cyc), .pulse_cnt(pulse_cnt),
        .pulse_cyc(pulse_cyc));
    // Clock of 10 ns period.
    initial begin
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    // Prints the counts and the verdict, then stops.
    task automatic end_of_test;
        $display("Totals: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    // Cuts a hang short.
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            end_of_test();
        end
    end
    // Compares one value against its expectation.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One-cycle register write and read.
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge SYS_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        @(negedge SYS_CLK);
        d = REG_RDATA;
    endtask : reg_rd
    // Control byte from frequency, speed, display, compensation and comparator.
    function automatic logic [7:0] mk(input int f, input int s, input int d, input int comp, input int cmp);
        return {comp[0], d[1:0], s[1:0], f[0], cmp[0], 1'b1};
    endfunction : mk
    function automatic logic [6:0] exp_res(input logic cmp, input logic [1:0] fc, input logic [1:0] sc);
        if (!cmp) return 7'h7f;
        return ~{fc == 2'h1, fc == 2'h0, fc == 2'h2, sc == 2'h1, sc == 2'h0, sc == 2'h2, fc == 2'h0 && sc == 2'h0};
    endfunction : exp_res
    // One test: mode 0 trigger, 1 key, 2 wait for a test the handler refired; a start is poked mid-test.
    task automatic run_test(input string name, input logic [7:0] ctrl, input logic [7:0] pnl, input int mode,
                            input bit load, input logic [1:0] fc, input logic [1:0] sc);
        int f, s, d, ticks;
        logic [31:0] rd;
        f = ctrl[2];
        s = ctrl[4:3];
        d = ctrl[6:5];
        ticks = base_t[f][s] + (ctrl[7] ? 10 : 0) + (ctrl[1] ? 1 : 0) + (d == 3 ? 10 : (d == 0 ? 0 : 15));
        if (mode != 2) reg_wr(etm_pkg::CTRL_OFS, {24'h0, ctrl});
        @(posedge SYS_CLK);
        FIRST_CMP_CODE <= fc;
        SECOND_CMP_CODE <= sc;
        panel <= pnl;
        fire <= (mode == 0);
        START_KEY <= (mode == 1);
        @(posedge SYS_CLK);
        fire <= 1'b0;
        START_KEY <= 1'b0;
        wait (MEASURE_BUSY_N === 1'b0);
        @(posedge SYS_CLK);
        fire <= 1'b1;
        START_KEY <= 1'b1;
        @(posedge SYS_CLK);
        fire <= 1'b0;
        START_KEY <= 1'b0;
        wait (MEASURE_BUSY_N === 1'b1);
        @(negedge SYS_CLK);
        check({name, " results"}, results, exp_res(ctrl[1], fc, sc));
        @(negedge SYS_CLK);
        check({name, " busy ticks"}, (busy_cyc + 2) / 4, ticks);
        check({name, " pulses"}, pulse_cnt, ap_n[f][s]);
        check({name, " width"}, (pulse_cyc + 2) / 4, ap_t[f][s]);
        if (mode != 1) check({name, " delay"}, load ? (delay_cyc >= 28 && delay_cyc <= 40)
                                                    : (delay_cyc >= 15 && delay_cyc <= 27), 1);
        tests++;
        reg_rd(etm_pkg::COUNT_OFS, rd);
        check({name, " count"}, rd, tests);
        $display("Test %s done", name);
    endtask : run_test
    // Main sequence.
    initial begin
        logic [31:0] rd;
        repeat (3) @(posedge SYS_CLK);
        RESET <= 1'b0;
        reg_rd(etm_pkg::CTRL_OFS, rd);
        check("ctrl reset", rd, 32'h0);
        reg_rd(8'h0c, rd);
        check("unmapped", rd, 32'h0);
        fire <= 1'b1;
        @(posedge SYS_CLK);
        fire <= 1'b0;
        repeat (40) @(posedge SYS_CLK);
        check("external mode off", MEASURE_BUSY_N, 1'b1);
        for (int f = 0; f < 2; f++) for (int s = 0; s < 3; s++)
            run_test("speed", mk(f, s, 0, 0, 1), 8'h00, 0, 0, 2'h0, 2'h0);
        for (int d = 0; d < 4; d++)
            run_test("display", mk(1, 0, d, d % 2, 1), 8'h00, 0, 0, 2'(d), 2'(d == 0 ? 0 : 3 - d));
        run_test("panel load", mk(1, 0, 0, 0, 1), 8'h25, 0, 1, 2'h1, 2'h0);
        run_test("panel same", mk(1, 0, 0, 0, 1), 8'h25, 0, 0, 2'h0, 2'h2);
        run_test("panel invalid", mk(1, 0, 0, 0, 1), 8'h1a, 0, 0, 2'h2, 2'h1);
        run_test("key", mk(1, 0, 0, 0, 0), 8'h25, 1, 0, 2'h1, 2'h2);
        retrig <= 1'b1;
        run_test("back to back one", mk(1, 0, 0, 0, 1), 8'h25, 0, 0, 2'h0, 2'h0);
        retrig <= 1'b0;
        run_test("back to back two", mk(1, 0, 0, 0, 1), 8'h25, 2, 0, 2'h0, 2'h1);
        reg_wr(etm_pkg::COUNT_OFS, 32'h0);
        reg_rd(etm_pkg::COUNT_OFS, rd);
        check("count write ignored", rd, tests);
        reg_rd(etm_pkg::STATUS_OFS, rd);
        check("status idle panel", rd, 32'h1902);
        reg_rd(etm_pkg::CTRL_OFS, rd);
        check("ctrl readback", rd, {24'h0, mk(1, 0, 0, 0, 1)});
        end_of_test();
    end
endmodule : etm_handshake_tb_top
`default_nettype wire
